// ---- core/cam_pkg.sv ----
// constants, register map and carrier types of the acceptance mask and buffer status block
package cam_pkg;
  localparam int NUM_FILTERS = 8;
  localparam int NUM_MASKS = 3;
  localparam int NUM_RXBUF = 32;
  localparam int NUM_TRB = 8;
  localparam int SID_W = 11;
  localparam int EID_W = 18;
  localparam int EID_HI_W = 2;
  localparam int BUF_IDX_W = 5;
  localparam int TRB_IDX_W = 3;
  localparam int MSRC_W = 2;
  localparam int MIDX_W = 2;
  localparam int PIDX_W = 2;
  localparam int REG_W = 16;
  localparam int BYTE_W = 8;
  localparam int PAIR_N = 2;
  localparam int IDX_LSB = 2;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // field positions in the standard identifier mask word
  localparam int SIDR_SID_LSB = 5;
  localparam int SIDR_TYPE_MATCH = 3;
  // byte addresses of the register file
  localparam logic [ADDR_W-1:0] ADDR_MSKSEL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_MSID0 = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_MEID0 = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_FUL_LO = 8'h1c;
  localparam logic [ADDR_W-1:0] ADDR_FUL_HI = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_OVF_LO = 8'h24;
  localparam logic [ADDR_W-1:0] ADDR_OVF_HI = 8'h28;
  localparam logic [ADDR_W-1:0] ADDR_CTRL0 = 8'h2c;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h3c;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h40;
  localparam logic [ADDR_W-1:0] MASK_SPAN = 8'h0c;
  localparam logic [ADDR_W-1:0] CTRL_SPAN = 8'h10;
  localparam logic [REG_W-1:0] RST16 = 16'h0000;
  // mask source code meaning no mask applies
  localparam logic [MSRC_W-1:0] MSRC_NONE = 2'h3;
  // interrupt status bit positions
  localparam int IRQ_RX_BUFFER_FULL_FLAG = 0;
  localparam int IRQ_OVF = 1;
  localparam int IRQ_TXDONE = 2;
  localparam int IRQ_ABT = 3;
  localparam int IRQ_LARB = 4;
  localparam int IRQ_ERR = 5;
  localparam int IRQ_W = 6;

  typedef struct packed {
    logic [SID_W-1:0] standard_identifier_bits;
    logic ide;
    logic rtr;
    logic [EID_W-1:0] extended_identifier_bits;
  } cam_frame_t;

  typedef struct packed {
    logic [SID_W-1:0] standard_identifier_bits;
    logic filter_extended_select;
    logic [EID_W-1:0] extended_identifier_bits;
  } cam_filter_t;

  typedef struct packed {
    logic [SID_W-1:0] standard_identifier_bits;
    logic id_type_match_enable;
    logic [EID_W-1:0] extended_identifier_bits;
  } cam_mask_t;

  // one control byte, bit 7 down to bit 0
  typedef struct packed {
    logic dir;
    logic abt;
    logic larb;
    logic err;
    logic req;
    logic auto_remote_reply_enable;
    logic [1:0] pri;
  } cam_ctrl_t;

  typedef struct packed {
    logic done;
    logic aborted;
    logic arb_lost;
    logic bus_err;
    logic [TRB_IDX_W-1:0] idx;
  } cam_txev_t;
endpackage

// ---- core/cam_filter_match.sv ----
// identifier comparison of one acceptance filter under its selected mask
`timescale 1ns/1ps
module cam_filter_match
  import cam_pkg::*;
(
  // received frame and filter setup
  input wire cam_frame_t frame,
  input wire cam_filter_t filt,
  input wire cam_mask_t mask,
  input wire logic mask_on,
  // result
  output logic hit
);
  logic [SID_W-1:0] sid_care;
  logic [EID_W-1:0] eid_care;
  logic type_strict;
  logic sid_ok;
  logic eid_ok;
  logic type_ok;

  // without a mask every position is compared and the type must agree
  assign sid_care = mask_on ? mask.standard_identifier_bits : {SID_W{1'b1}}; // R1 R2
  assign eid_care = mask_on ? mask.extended_identifier_bits : {EID_W{1'b1}}; // R3
  assign type_strict = mask_on ? mask.id_type_match_enable : 1'b1;
  assign sid_ok = ((frame.standard_identifier_bits ^ filt.standard_identifier_bits) & sid_care) == {SID_W{1'b0}}; // R16
  // a standard frame carries no extended bits, so they cannot disagree
  assign eid_ok = !frame.ide || (((frame.extended_identifier_bits ^ filt.extended_identifier_bits) & eid_care) == {EID_W{1'b0}}); // R16
  assign type_ok = !type_strict || (frame.ide == filt.filter_extended_select); // R4 R5 R15
  assign hit = sid_ok && eid_ok && type_ok;
endmodule

// ---- core/cam_top.sv ----
// register file, receive flags and transmit buffer control of the acceptance block
`timescale 1ns/1ps
//Contract
// R1: two-bit mask source per filter, 11 none
// R2: standard mask bit one compares, zero ignores
// R3: extended mask bit one compares, zero ignores
// R4: type match on: frame type must equal filter
// R5: type match off: any type if bits match
// R6: store sets full; only software clears it
// R7: message into full buffer sets overflow
// R8: software clears overflow; resets to zero
// R9: direction bit one transmit, zero receive
// R10: aborted flag set on abort, clear on success
// R11: arbitration lost flag set per buffer
// R12: bus error flag set during own transmission
// R13: request starts send; done clears; clear aborts
// R14: matching remote frame sets request if enabled
// R15: extended select picks frame type when strict
// R16: unmasked received bits equal stored bits
module cam_top
  import cam_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // receive side of the protocol engine
  input wire logic rx_valid,
  input wire cam_frame_t rx_frame,
  input wire logic [NUM_FILTERS-1:0] flt_en,
  input wire cam_filter_t [NUM_FILTERS-1:0] flt_cfg,
  input wire logic [NUM_FILTERS-1:0][BUF_IDX_W-1:0] flt_buf,
  // transmit side of the protocol engine
  input wire cam_txev_t tx_evt,
  output logic [NUM_TRB-1:0] tx_req,
  output logic [NUM_TRB-1:0] tx_abort_req,
  output logic [NUM_TRB-1:0] tx_dir,
  output logic [NUM_TRB-1:0][1:0] tx_prio,
  // interrupt
  output logic irq
);
  logic [REG_W-1:0] msk_sel;
  cam_mask_t mask [NUM_MASKS];
  logic [NUM_RXBUF-1:0] rx_full;
  logic [NUM_RXBUF-1:0] rx_ovf;
  cam_ctrl_t [NUM_TRB-1:0] ctrl;
  cam_ctrl_t [NUM_TRB-1:0] next_ctrl;
  logic [NUM_TRB-1:0] abort_pend;
  logic [NUM_TRB-1:0] next_pend;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_ev;
  logic setup;
  logic acc_wr;
  logic acc_rd;
  logic [DATA_W-1:0] next_rdata;
  logic next_err;
  logic [ADDR_W-1:0] off_msid;
  logic [ADDR_W-1:0] off_meid;
  logic [ADDR_W-1:0] off_ctrl;
  logic [NUM_FILTERS-1:0] hit;
  logic win;
  logic [BUF_IDX_W-1:0] win_buf;
  logic tgt_tx;
  logic rx_store;
  logic reply;
  logic full_hit;
  logic [NUM_RXBUF-1:0] buf_onehot;
  logic full_wr;
  logic [NUM_RXBUF-1:0] full_clr;
  logic [NUM_RXBUF-1:0] ovf_clr;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // address of word k of a register group
  function automatic logic at(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base,
                              input logic [ADDR_W-1:0] k);
    at = (a == base + ADDR_W'(k << IDX_LSB));
  endfunction

  // write-zero-to-clear word: a one leaves the flag alone
  function automatic logic [REG_W-1:0] clr_word(input logic wr, input logic [REG_W-1:0] d);
    clr_word = wr ? ~d : RST16;
  endfunction

  // apb phase decode
  assign setup = psel && !penable;
  assign acc_wr = psel && penable && pready && pwrite;
  assign acc_rd = psel && penable && pready && !pwrite;
  assign off_msid = paddr - ADDR_MSID0;
  assign off_meid = paddr - ADDR_MEID0;
  assign off_ctrl = paddr - ADDR_CTRL0;

  // one filter comparator each, fed by the mask its source field picks
  for (genvar f = 0; f < NUM_FILTERS; f++) begin : g_flt
    logic [MSRC_W-1:0] src;
    assign src = msk_sel[f*MSRC_W +: MSRC_W];
    cam_filter_match u_match (
      .frame(rx_frame),
      .filt(flt_cfg[f]),
      .mask(mask[(src == MSRC_NONE) ? 2'h0 : src]), // R1
      .mask_on(src != MSRC_NONE), // R1
      .hit(hit[f])
    );
  end

  // lowest enabled filter that hits decides the target buffer
  always_comb begin
    win = 1'b0;
    win_buf = {BUF_IDX_W{1'b0}};
    for (int i = NUM_FILTERS - 1; i >= 0; i--) begin
      if (rx_valid && flt_en[i] && hit[i]) begin
        win = 1'b1;
        win_buf = flt_buf[i];
      end
    end
  end

  // a frame aimed at a transmit buffer is never stored, at most answered
  assign tgt_tx = (win_buf < BUF_IDX_W'(NUM_TRB)) && ctrl[win_buf[TRB_IDX_W-1:0]].dir;
  assign rx_store = win && !tgt_tx;
  assign reply = win && tgt_tx && rx_frame.rtr && ctrl[win_buf[TRB_IDX_W-1:0]].auto_remote_reply_enable; // R14
  assign buf_onehot = {{(NUM_RXBUF-1){1'b0}}, 1'b1} << win_buf;
  assign full_hit = |(rx_full & buf_onehot);
  assign full_wr = acc_wr && (paddr == ADDR_FUL_LO || paddr == ADDR_FUL_HI);
  assign full_clr = {clr_word(acc_wr && paddr == ADDR_FUL_HI, pwdata[REG_W-1:0]),
                     clr_word(acc_wr && paddr == ADDR_FUL_LO, pwdata[REG_W-1:0])};
  assign ovf_clr = {clr_word(acc_wr && paddr == ADDR_OVF_HI, pwdata[REG_W-1:0]),
                    clr_word(acc_wr && paddr == ADDR_OVF_LO, pwdata[REG_W-1:0])};

  // mask source selection
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      msk_sel <= RST16;
    end else if (acc_wr && paddr == ADDR_MSKSEL) begin
      msk_sel <= pwdata[REG_W-1:0];
    end
  end

  // acceptance masks; reserved bits of the standard word are not stored
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int m = 0; m < NUM_MASKS; m++) mask[m] <= '0;
    end else begin
      for (int m = 0; m < NUM_MASKS; m++) begin
        if (acc_wr && at(paddr, ADDR_MSID0, ADDR_W'(m))) begin
          mask[m].standard_identifier_bits <= pwdata[SIDR_SID_LSB +: SID_W];
          mask[m].id_type_match_enable <= pwdata[SIDR_TYPE_MATCH];
          mask[m].extended_identifier_bits[EID_W-1 -: EID_HI_W] <= pwdata[EID_HI_W-1:0];
        end
        if (acc_wr && at(paddr, ADDR_MEID0, ADDR_W'(m))) begin
          mask[m].extended_identifier_bits[REG_W-1:0] <= pwdata[REG_W-1:0];
        end
      end
    end
  end

  // full and overflow flags: the module only sets, software only clears
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_full <= {NUM_RXBUF{1'b0}};
      rx_ovf <= {NUM_RXBUF{1'b0}};
    end else begin
      rx_full <= (rx_full & ~full_clr) | (rx_store ? buf_onehot : {NUM_RXBUF{1'b0}}); // R6
      rx_ovf <= (rx_ovf & ~ovf_clr) | ((rx_store && full_hit) ? buf_onehot : {NUM_RXBUF{1'b0}}); // R7 R8
    end
  end

  // buffer control: software write first, engine events after so their sets win
  always_comb begin
    cam_ctrl_t wb;
    logic sw_set;
    wb = '0;
    sw_set = 1'b0;
    next_ctrl = ctrl;
    next_pend = abort_pend;
    for (int t = 0; t < NUM_TRB; t++) begin
      wb = cam_ctrl_t'(pwdata[(t % PAIR_N) * BYTE_W +: BYTE_W]);
      sw_set = 1'b0;
      if (acc_wr && at(paddr, ADDR_CTRL0, ADDR_W'(t / PAIR_N))) begin
        next_ctrl[t].dir = wb.dir; // R9
        next_ctrl[t].auto_remote_reply_enable = wb.auto_remote_reply_enable;
        next_ctrl[t].pri = wb.pri;
        next_ctrl[t].req = wb.req; // R13
        if (wb.req && !ctrl[t].req) begin
          // a fresh request starts with clean outcome flags
          sw_set = 1'b1;
          next_ctrl[t].abt = 1'b0;
          next_ctrl[t].larb = 1'b0;
          next_ctrl[t].err = 1'b0;
        end
        if (!wb.req && ctrl[t].req) begin
          next_pend[t] = 1'b1; // R13
        end
      end
      if (tx_evt.idx == TRB_IDX_W'(t)) begin
        if (tx_evt.done) begin
          next_ctrl[t].abt = 1'b0; // R10
          next_ctrl[t].err = 1'b0; // R12
          next_pend[t] = 1'b0;
          if (!sw_set) next_ctrl[t].req = 1'b0; // R13
        end
        if (tx_evt.aborted) begin
          next_ctrl[t].abt = 1'b1; // R10
          next_pend[t] = 1'b0;
          if (!sw_set) next_ctrl[t].req = 1'b0;
        end
        if (tx_evt.arb_lost) next_ctrl[t].larb = 1'b1; // R11
        if (tx_evt.bus_err) next_ctrl[t].err = 1'b1; // R12
      end
      if (reply && win_buf == BUF_IDX_W'(t)) next_ctrl[t].req = 1'b1; // R14
    end
  end

  // control state
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= '0;
      abort_pend <= {NUM_TRB{1'b0}};
    end else begin
      ctrl <= next_ctrl;
      abort_pend <= next_pend;
    end
  end

  // engine facing copies of control bits
  always_comb begin
    for (int t = 0; t < NUM_TRB; t++) begin
      tx_req[t] = ctrl[t].req;
      tx_dir[t] = ctrl[t].dir;
      tx_prio[t] = ctrl[t].pri;
    end
  end
  assign tx_abort_req = abort_pend;

  // interrupt events
  assign irq_ev[IRQ_RX_BUFFER_FULL_FLAG] = rx_store && !full_hit;
  assign irq_ev[IRQ_OVF] = rx_store && full_hit;
  assign irq_ev[IRQ_TXDONE] = tx_evt.done;
  assign irq_ev[IRQ_ABT] = tx_evt.aborted;
  assign irq_ev[IRQ_LARB] = tx_evt.arb_lost;
  assign irq_ev[IRQ_ERR] = tx_evt.bus_err;

  // read clears only what the read returned, so an event in between survives
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat <= {IRQ_W{1'b0}};
    end else if (acc_rd && paddr == ADDR_IRQ_STAT) begin
      irq_stat <= (irq_stat & ~prdata[IRQ_W-1:0]) | irq_ev;
    end else begin
      irq_stat <= irq_stat | irq_ev;
    end
  end

  // interrupt mask
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_mask <= {IRQ_W{1'b0}};
    end else if (acc_wr && paddr == ADDR_IRQ_MASK) begin
      irq_mask <= pwdata[IRQ_W-1:0];
    end
  end

  // registered interrupt line, one cycle behind the status
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end

  // read data mux; misaligned or unmapped addresses answer with an error
  always_comb begin
    next_rdata = {DATA_W{1'b0}};
    next_err = 1'b0;
    if (paddr[IDX_LSB-1:0] != 2'h0) begin
      next_err = 1'b1;
    end else if (paddr == ADDR_MSKSEL) begin
      next_rdata[REG_W-1:0] = msk_sel;
    end else if (paddr >= ADDR_MSID0 && off_msid < MASK_SPAN) begin
      next_rdata[REG_W-1:0] = {mask[off_msid[IDX_LSB +: MIDX_W]].standard_identifier_bits, 1'b0,
                               mask[off_msid[IDX_LSB +: MIDX_W]].id_type_match_enable, 1'b0,
                               mask[off_msid[IDX_LSB +: MIDX_W]].extended_identifier_bits[EID_W-1 -: EID_HI_W]};
    end else if (paddr >= ADDR_MEID0 && off_meid < MASK_SPAN) begin
      next_rdata[REG_W-1:0] = mask[off_meid[IDX_LSB +: MIDX_W]].extended_identifier_bits[REG_W-1:0];
    end else if (paddr == ADDR_FUL_LO) begin
      next_rdata[REG_W-1:0] = rx_full[REG_W-1:0];
    end else if (paddr == ADDR_FUL_HI) begin
      next_rdata[REG_W-1:0] = rx_full[NUM_RXBUF-1:REG_W];
    end else if (paddr == ADDR_OVF_LO) begin
      next_rdata[REG_W-1:0] = rx_ovf[REG_W-1:0];
    end else if (paddr == ADDR_OVF_HI) begin
      next_rdata[REG_W-1:0] = rx_ovf[NUM_RXBUF-1:REG_W];
    end else if (paddr >= ADDR_CTRL0 && off_ctrl < CTRL_SPAN) begin
      next_rdata[REG_W-1:0] = ctrl[off_ctrl[IDX_LSB +: PIDX_W] * PAIR_N +: PAIR_N];
    end else if (paddr == ADDR_IRQ_STAT) begin
      next_rdata[IRQ_W-1:0] = irq_stat;
    end else if (paddr == ADDR_IRQ_MASK) begin
      next_rdata[IRQ_W-1:0] = irq_mask;
    end else begin
      next_err = 1'b1;
    end
  end

  // answer is prepared in the setup cycle so every apb output is a flop
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= {DATA_W{1'b0}};
    end else begin
      pready <= setup;
      pslverr <= setup && next_err;
      if (setup) prdata <= next_rdata;
    end
  end

  // checks on filter 0 against mask 0 or no mask, then on the receive flags and buffer control
  AST_NOMASK: assert property ( // R1
    rx_valid && msk_sel[MSRC_W-1:0] == MSRC_NONE && rx_frame.standard_identifier_bits != flt_cfg[0].standard_identifier_bits |-> !hit[0])
    else $error("filter without mask hit on differing standard bits");
  AST_SID_MASK: assert property ( // R2
    rx_valid && msk_sel[MSRC_W-1:0] == 2'h0 && ((rx_frame.standard_identifier_bits ^ flt_cfg[0].standard_identifier_bits) & mask[0].standard_identifier_bits) != 11'h000
    |-> !hit[0]) else $error("masked-in standard bit mismatch still hit");
  AST_EID_MASK: assert property ( // R3
    rx_valid && msk_sel[MSRC_W-1:0] == 2'h0 && rx_frame.ide
    && ((rx_frame.extended_identifier_bits ^ flt_cfg[0].extended_identifier_bits) & mask[0].extended_identifier_bits) != 18'h00000 |-> !hit[0])
    else $error("masked-in extended bit mismatch still hit");
  AST_TYPE_STRICT: assert property ( // R4
    rx_valid && msk_sel[MSRC_W-1:0] == 2'h0 && mask[0].id_type_match_enable
    && rx_frame.ide != flt_cfg[0].filter_extended_select |-> !hit[0]) else $error("strict type mode accepted wrong type");
  AST_TYPE_FREE: assert property ( // R5
    rx_valid && msk_sel[MSRC_W-1:0] == 2'h0 && !mask[0].id_type_match_enable && !rx_frame.ide
    && flt_cfg[0].filter_extended_select && ((rx_frame.standard_identifier_bits ^ flt_cfg[0].standard_identifier_bits) & mask[0].standard_identifier_bits) == 11'h000 |-> hit[0])
    else $error("free type mode rejected matching frame");
  AST_FULL_SET: assert property ( // R6
    rx_store |=> (rx_full & $past(buf_onehot)) != 32'h00000000)
    else $error("stored frame did not set full flag");
  AST_FULL_KEEP: assert property ( // R6
    (|($past(rx_full) & ~rx_full)) |-> $past(full_wr))
    else $error("full flag dropped without software write");
  AST_OVF_SET: assert property ( // R7
    rx_store && full_hit |=> (rx_ovf & $past(buf_onehot)) != 32'h00000000 ##1 1'b1)
    else $error("write to full buffer did not set overflow");
  AST_DIR_WR: assert property ( // R9
    acc_wr && paddr == ADDR_CTRL0 |=> ctrl[0].dir == $past(pwdata[BYTE_W-1]))
    else $error("direction bit did not take written value");
  AST_ABORT: assert property ( // R10
    tx_evt.aborted |=> ctrl[$past(tx_evt.idx)].abt && !tx_abort_req[$past(tx_evt.idx)])
    else $error("abort event not reflected");
  AST_DONE_CLEAN: assert property ( // R10
    tx_evt.done && !tx_evt.aborted |=> !ctrl[$past(tx_evt.idx)].abt)
    else $error("aborted flag set after successful send");
  AST_LARB: assert property ( // R11
    tx_evt.arb_lost |=> ctrl[$past(tx_evt.idx)].larb) else $error("lost arbitration not flagged");
  AST_ERR: assert property ( // R12
    tx_evt.bus_err |=> ctrl[$past(tx_evt.idx)].err) else $error("bus error not flagged");
  AST_REQ_DONE: assert property ( // R13
    tx_evt.done && !acc_wr && !reply |=> !tx_req[$past(tx_evt.idx)])
    else $error("send request not cleared after done");
  AST_REPLY: assert property ( // R14
    reply |=> tx_req[$past(win_buf[TRB_IDX_W-1:0])]) else $error("remote frame did not raise request");

  COV_STORE: cover property (rx_store && !full_hit);
  COV_OVF: cover property (rx_store && full_hit);
  COV_REPLY: cover property (reply);
  COV_ABORT: cover property (acc_wr ##[1:20] tx_evt.aborted);
endmodule

// ---- dv/cam_engine_model.sv ----
// transmit side of the protocol engine, answering send and abort requests
`timescale 1ns/1ps
module cam_engine_model
  import cam_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // requests from the block
  input wire logic [NUM_TRB-1:0] tx_req,
  input wire logic [NUM_TRB-1:0] tx_abort_req,
  // bench controls: outcome kind and answer latency
  input wire logic [1:0] kind,
  input wire logic [3:0] lat,
  // events back to the block
  output cam_txev_t tx_evt
);
  logic [3:0] cnt;
  logic [NUM_TRB-1:0] seen;
  logic [NUM_TRB-1:0] pend;
  logic lost;
  int i;

  // a buffer that hit a bus error is left waiting until software gives up on it
  assign pend = tx_abort_req | (tx_req & ~seen);

  // lowest pending buffer is served first
  always_comb begin
    i = 0;
    for (int k = NUM_TRB - 1; k >= 0; k--) if (pend[k]) i = k;
  end

  // kind 0 completes, 1 loses arbitration once then completes, 2 signals a bus error and stalls
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_evt <= '0;
      cnt <= 4'h0;
      seen <= '0;
      lost <= 1'b0;
    end else begin
      tx_evt <= '0;
      seen <= seen & tx_req;
      cnt <= (pend != '0) ? cnt + 4'h1 : 4'h0;
      if (pend != '0 && cnt == lat) begin
        cnt <= 4'h0;
        tx_evt.idx <= i[TRB_IDX_W-1:0];
        if (tx_abort_req[i]) begin
          tx_evt.aborted <= 1'b1;
        end else if (kind == 2'd2) begin
          tx_evt.bus_err <= 1'b1;
          seen[i] <= 1'b1;
        end else if (kind == 2'd1 && !lost) begin
          tx_evt.arb_lost <= 1'b1;
          lost <= 1'b1;
        end else begin
          tx_evt.done <= 1'b1;
          lost <= 1'b0;
        end
      end
    end
  end
endmodule

// ---- dv/cam_top_tb_top.sv ----
// self-checking bench of the acceptance mask and buffer status block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin n_errors++; $display("Error %s expected %h seen %h", nm, exp, got); end end
module cam_top_tb_top;
  import cam_pkg::*;
  logic sys_clk, reset_n, psel, penable, pwrite, pready, pslverr, rx_valid, irq, err;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  cam_frame_t rx_frame, fr;
  logic [NUM_FILTERS-1:0] flt_en;
  cam_filter_t [NUM_FILTERS-1:0] flt_cfg;
  logic [NUM_FILTERS-1:0][BUF_IDX_W-1:0] flt_buf;
  cam_txev_t tx_evt;
  logic [NUM_TRB-1:0] tx_req, tx_abort_req, tx_dir, tdir, tren;
  logic [NUM_TRB-1:0][1:0] tx_prio;
  logic [1:0] kind;
  logic [3:0] lat;
  cam_mask_t masks [NUM_MASKS];
  logic [2*NUM_FILTERS-1:0] msel;
  logic [NUM_RXBUF-1:0] ful, ovf;
  int n_errors, n_tests;

  cam_top uut (.sys_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .rx_valid, .rx_frame, .flt_en, .flt_cfg, .flt_buf, .tx_evt, .tx_req, .tx_abort_req, .tx_dir, .tx_prio, .irq);
  cam_engine_model eng (.sys_clk, .reset_n, .tx_req, .tx_abort_req, .kind, .lat, .tx_evt);

  // 250 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // one apb transfer; waits as long as the slave needs, only the watchdog ends a dead wait
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // reference acceptance test of one filter
  function automatic logic hit_m(cam_frame_t f, cam_filter_t c, logic [1:0] s);
    cam_mask_t m;
    m = (s == MSRC_NONE) ? '1 : masks[s];
    if (m.id_type_match_enable && f.ide != c.filter_extended_select) return 1'b0;
    if (((f.standard_identifier_bits ^ c.standard_identifier_bits) & m.standard_identifier_bits) != '0) return 1'b0;
    return !f.ide || ((f.extended_identifier_bits ^ c.extended_identifier_bits) & m.extended_identifier_bits) == '0;
  endfunction

  // send a frame, update the reference flags, compare all four flag registers
  task automatic rx_check(input cam_frame_t f);
    int w;
    int b;
    w = -1;
    for (int k = NUM_FILTERS - 1; k >= 0; k--) if (flt_en[k] && hit_m(f, flt_cfg[k], msel[2*k+:2])) w = k;
    b = (w < 0) ? -1 : int'(flt_buf[w]);
    if (b >= 0 && !(b < NUM_TRB && tdir[b])) begin
      if (ful[b]) ovf[b] = 1'b1;
      else ful[b] = 1'b1;
    end
    @(posedge sys_clk);
    rx_valid <= 1'b1;
    rx_frame <= f;
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    repeat (2) @(posedge sys_clk);
    for (int k = 0; k < 4; k++) begin
      apb(1'b0, ADDR_FUL_LO + 8'(4*k), '0);
      `CHK("rx_flags", (k < 2) ? 32'(ful[16*k+:16]) : 32'(ovf[16*(k-2)+:16]), rd)
    end
  endtask

  // mask registers and mask selection, with read-back of the selection and the standard mask words
  task automatic load_cfg();
    logic [DATA_W-1:0] e;
    apb(1'b1, ADDR_MSKSEL, 32'(msel));
    apb(1'b0, ADDR_MSKSEL, '0);
    `CHK("mask_select", 32'(msel), rd)
    for (int m = 0; m < NUM_MASKS; m++) begin
      // reserved bits 4 and 2 are written as ones and must read back as zeros
      e = {16'h0, masks[m].standard_identifier_bits, 1'b0, masks[m].id_type_match_enable, 1'b0, masks[m].extended_identifier_bits[17:16]};
      apb(1'b1, ADDR_MSID0 + 8'(4*m), e | 32'h14);
      apb(1'b0, ADDR_MSID0 + 8'(4*m), '0);
      `CHK("mask_sid", e, rd)
      apb(1'b1, ADDR_MEID0 + 8'(4*m), 32'(masks[m].extended_identifier_bits[15:0]));
    end
  endtask

  // control write of buffer 0, wait for the engine, read the control byte back
  task automatic tx_wait(input logic [DATA_W-1:0] d, input logic [15:0] exp);
    int k;
    apb(1'b1, ADDR_CTRL0, d);
    @(posedge sys_clk);
    `CHK("dir", d[7], tx_dir[0])
    `CHK("prio", d[1:0], tx_prio[0])
    `CHK("req", d[3], tx_req[0])
    `CHK("abort_req", ~d[3], tx_abort_req[0])
    k = 0;
    while ((tx_req[0] | tx_abort_req[0]) !== 1'b0 && k < 30) begin
      @(posedge sys_clk);
      k++;
    end
    apb(1'b0, ADDR_CTRL0, '0);
    `CHK("ctrl", {16'h0, exp}, rd)
  endtask

  task automatic finish_test();
    if (n_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // watchdog well beyond the expected run of under two thousand cycles
  initial begin
    repeat (40000) @(posedge sys_clk);
    n_errors++;
    finish_test();
  end

  initial begin
    int k;
    int j;
    logic [DATA_W-1:0] v;
    void'($urandom(32'h8d54db97));
    {psel, penable, pwrite, rx_valid} = 4'h0;
    paddr = '0;
    pwdata = '0;
    rx_frame = '0;
    flt_en = '0;
    flt_cfg = '0;
    flt_buf = '0;
    kind = 2'd0;
    lat = 4'd5;
    {ful, ovf, tdir, tren, msel} = '0;
    n_errors = 0;
    n_tests = 0;
    reset_n = 1'b0;
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    // every mapped register resets to zero; unmapped and misaligned are refused
    for (int a = 0; a <= 'h40; a += 4) begin
      apb(1'b0, 8'(a), '0);
      `CHK("reset_value", 32'h0, rd)
      `CHK("slverr", 1'b0, err)
    end
    for (int a = 0; a < 2; a++) begin
      apb(1'b0, a ? 8'h44 : 8'h02, '0);
      `CHK("unmapped", 1'b1, err)
    end
    // random filters, masks and near-miss frames, with software clears between
    repeat (3) begin
      for (k = 0; k < NUM_MASKS; k++) masks[k] = 30'($urandom);
      for (k = 0; k < NUM_FILTERS; k++) begin
        msel[2*k+:2] = 2'($urandom % 3);
        flt_cfg[k] <= 30'($urandom);
        flt_buf[k] <= 5'($urandom);
      end
      flt_en <= 8'($urandom) | 8'h01;
      load_cfg();
      repeat (12) begin
        k = $urandom % NUM_FILTERS;
        fr.standard_identifier_bits = flt_cfg[k].standard_identifier_bits ^ (11'($urandom) & 11'($urandom) & 11'($urandom));
        fr.ide = flt_cfg[k].filter_extended_select ^ ($urandom % 4 == 0);
        fr.rtr = 1'b0;
        fr.extended_identifier_bits = flt_cfg[k].extended_identifier_bits ^ (18'($urandom) & 18'($urandom) & 18'($urandom));
        rx_check(fr);
        j = $urandom % 4;
        v = $urandom;
        apb(1'b1, ADDR_FUL_LO + 8'(4*j), v);
        if (j < 2) ful[16*j+:16] &= v[15:0];
        else ovf[16*(j-2)+:16] &= v[15:0];
      end
    end
    `CHK("irq_masked", 1'b0, irq)
    // type match on and off, masked and compared bits, no-mask source
    flt_en <= 8'h01;
    flt_cfg[0] <= {11'h5a5, 1'b1, 18'h2a5a5};
    flt_buf[0] <= 5'd20;
    for (int t = 0; t < 16; t++) begin
      msel = t[3] ? '1 : '0;
      masks[0] = {11'h7fe, t[0], 18'h3fffe};
      load_cfg();
      rx_check({11'h5a5 ^ 11'(t[1]), ~t[2], 1'b0, 18'h2a5a5 ^ 18'(t[1])});
    end
    // unmasked store raises the interrupt; reading status drops it
    apb(1'b0, ADDR_IRQ_STAT, '0);
    apb(1'b1, ADDR_IRQ_MASK, 32'h1 << IRQ_RX_BUFFER_FULL_FLAG);
    apb(1'b1, ADDR_FUL_LO, '0);
    apb(1'b1, ADDR_FUL_HI, '0);
    ful = '0;
    rx_check({11'h5a5, 1'b1, 1'b0, 18'h2a5a5});
    `CHK("irq_set", 1'b1, irq)
    apb(1'b0, ADDR_IRQ_STAT, '0);
    `CHK("irq_status", 1'b1, rd[IRQ_RX_BUFFER_FULL_FLAG])
    repeat (2) @(posedge sys_clk);
    `CHK("irq_clear", 1'b0, irq)
    // transmit outcomes: completion, lost arbitration, bus error, abort
    lat <= 4'(4 + $urandom % 5);
    tx_wait(32'h8a, 16'h82);
    kind <= 2'd1;
    tx_wait(32'h8a, 16'ha2);
    kind <= 2'd2;
    tx_wait(32'h8a, 16'h9a);
    tx_wait(32'h82, 16'hd2);
    // remote frame to a transmit buffer with auto reply: not stored, request set
    tdir = 8'h02;
    tren = 8'h02;
    apb(1'b1, ADDR_CTRL0, 32'h8400);
    flt_buf[0] <= 5'd1;
    `CHK("no_reply_yet", 1'b0, tx_req[1])
    rx_check({11'h5a5, 1'b1, 1'b1, 18'h2a5a5});
    `CHK("auto_reply", tren[1], tx_req[1])
    finish_test();
  end
endmodule
